// ### hdl/id_rom_regs.svh
/*
 * Register offsets, field positions, reset values and counts for the
 * interface version and unique-id ROM access registers.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef ID_ROM_REGS_SVH
`define ID_ROM_REGS_SVH

// Byte addresses on the 32-bit register bus
`define OFS_INTERFACE_VERSION 12'h000
`define OFS_ID_ROM_ACCESS 12'h004
`define APB_ADDR_W 12

// Version register fields
`define VER_MAJOR_VALUE 8'h01
`define VER_MINOR_VALUE 8'h10
`define VER_PRESENT_BIT 24

// ROM access register fields
`define ACC_ADDR_CLEAR_BIT 31
`define ACC_READ_START_BIT 25
`define ACC_DATA_LSB 16
`define ACC_DATA_MSB 23
`define SMALL_ROM_VALUE 8'h20
`define SMALL_ROM_CFG_ADDR 8'h06
`define SMALL_ROM_CFG_BIT 5

// Reset values
`define ROM_ADDR_RESET 8'h00
`define ROM_DATA_RESET 8'h00

// Node information block: bytes 0 through this index are auto-loaded
`define LOAD_LAST_ADDR 8'h13

// Cycles for the presence pin to pass its synchroniser after reset
`define SETTLE_CYCLES 3'h4

`endif

// ### hdl/id_rom_pkg.sv
/*
 * Types shared by the unique-id ROM access block: bus request carrier,
 * ROM byte port carriers and the sequencer state encoding.
 * Assumes id_rom_regs.svh is on the include path.
 */
`include "id_rom_regs.svh"

package id_rom_pkg;

  // APB request from the bus master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // Byte answer from the serial ROM engine
  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } rom_rsp_s;

  // Byte delivered by the automatic load
  typedef struct packed {
    logic valid;
    logic [7:0] index;
    logic [7:0] data;
  } load_byte_s;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_SETTLE = 5'h01,
    ST_LOAD_REQ = 5'h02,
    ST_LOAD_WAIT = 5'h04,
    ST_IDLE = 5'h08,
    ST_READ_WAIT = 5'h10
  } seq_state_e;

endpackage

// ### hdl/host_version_and_id_rom_access.sv
/*
 * Interface version register and byte-wise access to the unique-id
 * serial ROM, behind an APB slave. After every reset the block waits
 * for the presence pin to settle and, with a ROM attached, loads the
 * node information block through the ROM byte port.
 * Assumes a serial ROM engine on clk_in that takes a held request with
 * an address and answers with a one-cycle ack and the byte; the
 * presence pin is asynchronous.
 */
// The implementer's own choice: register access over APB.
// Contract
// - Version reserved bits read as zero
// - Version bit 24 shows ROM detected
// - Auto-load info block on every reset with a ROM attached
// - Version bits 23:16 read 01h
// - Version bits 7:0 read 10h
// - Byte reads only meaningful with ROM present
// - Access register reserved bits read zero
// - Bit 31 clears ROM address, self-clears
// - Address clear leaves read data untouched
// - Bit 25 reads addressed byte, self-clears
// - Fetched byte lands in bits 23:16
// - Small-ROM field 20h when byte 6 bit5
`include "id_rom_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module host_version_and_id_rom_access (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire id_rom_pkg::apb_req_s apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rom_detect_in,
  output logic rom_req_out,
  output logic [7:0] rom_addr_out,
  input wire id_rom_pkg::rom_rsp_s rom_rsp_in,
  output id_rom_pkg::load_byte_s load_out,
  output logic load_busy_out
);
  import id_rom_pkg::*;

  // Presence pin synchroniser and settle counter
  logic detect_meta;
  logic detect_sync;
  logic [2:0] settle_cnt;

  // Sequencer and register state
  seq_state_e state;
  seq_state_e next_state;
  logic rom_present_flag;
  logic rom_address_clear;
  logic byte_read_start;
  logic [7:0] byte_read_value;
  logic small_rom_indicator;
  logic [7:0] rom_addr;
  logic [7:0] next_rom_addr;
  logic rom_req;
  logic next_rom_req;

  // Bus decode wires
  wire access_phase = apb_in.psel & apb_in.penable;
  wire bus_commit = access_phase & pready_out;
  wire hit_version = apb_in.paddr == `OFS_INTERFACE_VERSION;
  wire hit_access = apb_in.paddr == `OFS_ID_ROM_ACCESS;
  wire hit_any = hit_version | hit_access;
  wire wr_access = bus_commit & apb_in.pwrite & hit_access;
  wire sw_set_clear = wr_access & apb_in.pwdata[`ACC_ADDR_CLEAR_BIT];
  wire sw_set_start = wr_access & apb_in.pwdata[`ACC_READ_START_BIT];

  // Sequencer event wires
  wire in_idle = state == ST_IDLE;
  wire settle_done = settle_cnt == `SETTLE_CYCLES;
  wire rom_ack = rom_req & rom_rsp_in.ack;
  wire load_ack = (state == ST_LOAD_WAIT) & rom_ack;
  wire load_last = rom_addr == `LOAD_LAST_ADDR;
  wire read_ack = (state == ST_READ_WAIT) & rom_ack;
  // Address clear goes first when both commands are pending
  wire do_clear = in_idle & rom_address_clear;
  wire do_start = in_idle & ~rom_address_clear & byte_read_start;
  wire start_dropped = do_start & ~rom_present_flag;
  wire start_issue = do_start & rom_present_flag;
  wire hw_done_clear = do_clear;
  wire hw_done_start = read_ack | start_dropped;
  wire cfg_byte = load_ack & (rom_addr == `SMALL_ROM_CFG_ADDR);

  // Register read images
  wire [31:0] version_image = {
    7'h00,
    rom_present_flag,
    `VER_MAJOR_VALUE,
    8'h00,
    `VER_MINOR_VALUE
  };
  wire [7:0] small_rom_field = small_rom_indicator ?
    `SMALL_ROM_VALUE : 8'h00;
  wire [31:0] access_image = {
    rom_address_clear,
    5'h00,
    byte_read_start,
    1'b0,
    byte_read_value,
    8'h00,
    small_rom_field
  };
  wire [31:0] read_mux = hit_version ? version_image :
    hit_access ? access_image : 32'h0000_0000;

  // Bus answer one cycle into the access phase
  wire answer_now = access_phase & ~pready_out;
  wire next_pready = answer_now;
  wire next_pslverr = answer_now & ~hit_any;
  wire [31:0] next_prdata = (answer_now & ~apb_in.pwrite) ? read_mux :
    32'h0000_0000;

  // Two-flop synchroniser on the presence pin
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      detect_meta <= 1'b0;
      detect_sync <= 1'b0;
    end else begin
      detect_meta <= rom_detect_in;
      detect_sync <= detect_meta;
    end
  end

  // Settle counter runs once after every reset release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      settle_cnt <= 3'h0;
    end else if (state == ST_SETTLE && !settle_done) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end

  // Presence is caught once the synchroniser has settled
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rom_present_flag <= 1'b0;
    end else if (state == ST_SETTLE && settle_done) begin
      rom_present_flag <= detect_sync;
    end
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_SETTLE: begin
        if (settle_done) begin
          // Auto-load only with a ROM attached
          next_state = detect_sync ? ST_LOAD_REQ : ST_IDLE;
        end
      end
      ST_LOAD_REQ: begin
        next_state = ST_LOAD_WAIT;
      end
      ST_LOAD_WAIT: begin
        if (load_ack) begin
          next_state = load_last ? ST_IDLE : ST_LOAD_REQ;
        end
      end
      ST_IDLE: begin
        if (start_issue) begin
          next_state = ST_READ_WAIT;
        end
      end
      ST_READ_WAIT: begin
        if (read_ack) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_SETTLE;
      end
    endcase
  end

  // ROM address: load walk, software clear, advance after reads
  always_comb begin
    next_rom_addr = rom_addr;
    if (state == ST_SETTLE) begin
      next_rom_addr = `ROM_ADDR_RESET;
    end else if (load_ack) begin
      // After the load the software pointer restarts at zero
      next_rom_addr = load_last ? `ROM_ADDR_RESET : rom_addr + 8'h01;
    end else if (do_clear) begin
      next_rom_addr = `ROM_ADDR_RESET;
    end else if (read_ack) begin
      next_rom_addr = rom_addr + 8'h01;
    end
  end

  // Request is raised on entry to a wait and held until ack
  always_comb begin
    next_rom_req = rom_req;
    if (state == ST_LOAD_REQ || start_issue) begin
      next_rom_req = 1'b1;
    end else if (rom_ack) begin
      next_rom_req = 1'b0;
    end
  end

  // Sequencer state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= ST_SETTLE;
    end else begin
      state <= next_state;
    end
  end

  // ROM byte address register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rom_addr <= `ROM_ADDR_RESET;
    end else begin
      rom_addr <= next_rom_addr;
    end
  end

  // Internal request register, mirrors the request output
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rom_req <= 1'b0;
    end else begin
      rom_req <= next_rom_req;
    end
  end

  // Address clear command; a software set beats the hardware clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rom_address_clear <= 1'b0;
    end else if (sw_set_clear) begin
      rom_address_clear <= 1'b1;
    end else if (hw_done_clear) begin
      rom_address_clear <= 1'b0;
    end
  end

  // Read start command; a software set beats the hardware clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      byte_read_start <= 1'b0;
    end else if (sw_set_start) begin
      byte_read_start <= 1'b1;
    end else if (hw_done_start) begin
      byte_read_start <= 1'b0;
    end
  end

  // Read data changes only on a completed byte read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      byte_read_value <= `ROM_DATA_RESET;
    end else if (read_ack) begin
      byte_read_value <= rom_rsp_in.data;
    end
  end

  // Small-ROM indicator from the configuration byte of the load
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      small_rom_indicator <= 1'b0;
    end else if (cfg_byte) begin
      small_rom_indicator <= rom_rsp_in.data[`SMALL_ROM_CFG_BIT];
    end
  end

  // Loaded bytes handed to the node information block
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      load_out <= '0;
    end else begin
      load_out.valid <= load_ack;
      if (load_ack) begin
        load_out.index <= rom_addr;
        load_out.data <= rom_rsp_in.data;
      end
    end
  end

  // Busy while settling or loading the information block
  wire next_busy = (next_state == ST_SETTLE) ||
    (next_state == ST_LOAD_REQ) || (next_state == ST_LOAD_WAIT);

  // ROM request output, held until the engine acks
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rom_req_out <= 1'b0;
    end else begin
      rom_req_out <= next_rom_req;
    end
  end

  // ROM address output, stable while a request stands
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rom_addr_out <= `ROM_ADDR_RESET;
    end else begin
      rom_addr_out <= next_rom_addr;
    end
  end

  // Busy output, high from reset until the load ends, or until the settle ends with no ROM
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      load_busy_out <= 1'b1;
    end else begin
      load_busy_out <= next_busy;
    end
  end

  // Bus ready pulse: exactly one wait state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= next_pready;
    end
  end

  // Bus error for unmapped addresses, with pready
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= next_pslverr;
    end
  end

  // Read data, zero outside the answer cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else begin
      prdata_out <= next_prdata;
    end
  end

endmodule

`default_nettype wire

// ### testbench/hv_checks_assertions.sv
/* Checker for the version and id-rom access block ports.
   Assumes one clock and a synchronous active-low reset. */
`include "id_rom_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module hv_checks (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire id_rom_pkg::apb_req_s apb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic rom_detect_in,
  input wire logic rom_req_out,
  input wire logic [7:0] rom_addr_out,
  input wire id_rom_pkg::rom_rsp_s rom_rsp_in,
  input wire id_rom_pkg::load_byte_s load_out,
  input wire logic load_busy_out
);
  import id_rom_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Completed reads of each register
  sequence s_ver_rd;
    pready_out && !apb_in.pwrite && apb_in.paddr == `OFS_INTERFACE_VERSION;
  endsequence
  sequence s_acc_rd;
    pready_out && !apb_in.pwrite && apb_in.paddr == `OFS_ID_ROM_ACCESS;
  endsequence
  ver_rsvd_a: assert property (
    s_ver_rd |-> prdata_out[31:25] == 7'h00 && prdata_out[15:8] == 8'h00)
    else $error("version reserved bits set");
  ver_present_a: assert property (
    s_ver_rd |-> prdata_out[24] == rom_detect_in)
    else $error("presence flag wrong");
  ver_fixed_a: assert property (
    s_ver_rd |-> prdata_out[23:16] == 8'h01 && prdata_out[7:0] == 8'h10)
    else $error("version fields wrong");
  acc_rsvd_a: assert property (
    s_acc_rd |-> prdata_out[30:26] == 5'h00 && !prdata_out[24]
      && prdata_out[15:8] == 8'h00)
    else $error("access reserved bits set");
  small_rom_a: assert property (
    s_acc_rd |-> prdata_out[7:0] inside {8'h00, 8'h20}
      && (rom_detect_in || prdata_out[7:0] == 8'h00))
    else $error("small rom field wrong");
  req_hold_a: assert property (
    rom_req_out && !rom_rsp_in.ack |=> rom_req_out && $stable(rom_addr_out))
    else $error("rom request dropped early");
  ack_drop_a: assert property (
    rom_req_out && rom_rsp_in.ack |=> !rom_req_out)
    else $error("rom request held after ack");
  load_pulse_a: assert property (
    rom_req_out && rom_rsp_in.ack && load_busy_out |-> ##[1:2] load_out.valid)
    else $error("loaded byte not delivered");
  absent_a: assert property (
    rom_req_out |-> rom_detect_in)
    else $error("rom request without rom");
  wait_state_a: assert property (
    $rose(apb_in.penable) && apb_in.psel |=> pready_out ##1 !pready_out)
    else $error("bus answer timing wrong");
  unmapped_a: assert property (
    pready_out && apb_in.paddr != `OFS_INTERFACE_VERSION
      && apb_in.paddr != `OFS_ID_ROM_ACCESS |-> pslverr_out
      && prdata_out == 32'h0)
    else $error("unmapped access not refused");
endmodule
bind host_version_and_id_rom_access hv_checks u_hv_checks (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(apb_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .rom_detect_in(rom_detect_in),
  .rom_req_out(rom_req_out), .rom_addr_out(rom_addr_out),
  .rom_rsp_in(rom_rsp_in), .load_out(load_out),
  .load_busy_out(load_busy_out));
`default_nettype wire

// ### testbench/id_rom_engine_model.sv
/* Behavioural serial rom engine: answers a held byte request after
   delay_in cycles with a one-cycle ack. Assumes the shared clock. */
`timescale 1ns/10ps
`default_nettype none
module id_rom_engine_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [7:0] addr_in,
  input wire logic [3:0] delay_in,
  output var id_rom_pkg::rom_rsp_s rsp_out
);
  import id_rom_pkg::*;
  logic [7:0] mem [256];
  logic [3:0] wait_cnt = 4'h0;
  initial rsp_out = '0;
  // Latency count, ack pulse; data toggles when not answering
  always @(posedge clk_in) begin
    if (req_in && !rsp_out.ack && wait_cnt >= delay_in) begin
      rsp_out.ack <= 1'b1;
      rsp_out.data <= mem[addr_in];
      wait_cnt <= 4'h0;
    end else begin
      rsp_out.ack <= 1'b0;
      rsp_out.data <= ~rsp_out.data;
      wait_cnt <= (req_in && !rsp_out.ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/host_version_and_id_rom_access_tb_top.sv
/* Self-checking bench: APB master, presence pin and rom engine model.
   Assumes the checker is bound to the block. */
`include "id_rom_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module host_version_and_id_rom_access_tb_top;
  import id_rom_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rom_detect_in = 1'b1;
  logic [3:0] delay = 4'h0;
  apb_req_s apb = '0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, rom_req_out, load_busy_out;
  logic [7:0] rom_addr_out;
  rom_rsp_s rom_rsp;
  load_byte_s load_out;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [15:0] ld_q[$];
  logic [15:0] ld;
  int num_errors = 0;
  int n_tests = 0;
  int i;
  host_version_and_id_rom_access u_host_version_and_id_rom_access (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(apb),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .rom_detect_in(rom_detect_in),
    .rom_req_out(rom_req_out), .rom_addr_out(rom_addr_out),
    .rom_rsp_in(rom_rsp), .load_out(load_out),
    .load_busy_out(load_busy_out));
  id_rom_engine_model u_id_rom_engine_model (.clk_in(clk_in),
    .req_in(rom_req_out), .addr_in(rom_addr_out), .delay_in(delay),
    .rsp_out(rom_rsp));
  initial forever #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) delay <= 4'($urandom % 6);
  task automatic check(input string what, input logic [32:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic apb_xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk_in);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_in);
    apb.penable <= 1'b1;
    // Hold the request until pready is seen; only the watchdog ends this
    do @(posedge clk_in); while (!pready_out);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    exp_q.push_back(34'h0);
    apb_xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    exp_q.push_back({1'b1, x});
    apb_xfer(1'b0, a, 32'h0);
  endtask
  task automatic wait_byte();
    int k;
    for (k = 0; k < 99 && !rom_req_out; k++) @(posedge clk_in);
    for (k = 0; k < 99 && rom_req_out; k++) @(posedge clk_in);
  endtask
  task automatic do_reset(input logic present);
    int k;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    rom_detect_in <= present;
    // Note every byte the automatic load should hand over
    for (k = 0; present && k <= `LOAD_LAST_ADDR; k++) begin
      ld_q.push_back({8'(k), u_id_rom_engine_model.mem[k]});
    end
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    for (k = 0; k < 2000 && load_busy_out; k++) @(posedge clk_in);
  endtask
  function automatic logic [32:0] acc(input logic [7:0] b, sm);
    return {9'h000, b, 8'h00, sm};
  endfunction
  // Pair each bus answer with the oldest note
  always @(posedge clk_in) begin
    if (pready_out) begin
      check("bus note", 33'(exp_q.size() != 0), 33'h1);
      e = exp_q.pop_front();
      if (e[33]) check("read", {pslverr_out, prdata_out}, e[32:0]);
      else check("write", {32'h0, pslverr_out}, 33'h0);
    end
    // Pair each loaded byte with the oldest load note
    if (load_out.valid) begin
      check("load note", 33'(ld_q.size() != 0), 33'h1);
      ld = ld_q.pop_front();
      check("load byte", {16'h0, load_out}, {17'h1, ld});
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    finish_test();
  end
  initial begin
    i = $urandom(74);
    for (i = 0; i < 256; i++) u_id_rom_engine_model.mem[i] = 8'($urandom);
    u_id_rom_engine_model.mem[6] |= 8'h20;
    do_reset(1'b1);
    rd(`OFS_INTERFACE_VERSION, 33'h0_0101_0010);
    wr(`OFS_INTERFACE_VERSION, 32'hFFFF_FFFF);
    rd(`OFS_INTERFACE_VERSION, 33'h0_0101_0010);
    rd(12'h008, 33'h1_0000_0000);
    $display("version tests done");
    wr(`OFS_ID_ROM_ACCESS, 32'h8000_0000);
    for (i = 0; i < 4; i++) begin
      wr(`OFS_ID_ROM_ACCESS, 32'h0200_0000);
      wait_byte();
      rd(`OFS_ID_ROM_ACCESS, acc(u_id_rom_engine_model.mem[i], 8'h20));
    end
    wr(`OFS_ID_ROM_ACCESS, 32'h8000_0000);
    rd(`OFS_ID_ROM_ACCESS, acc(u_id_rom_engine_model.mem[3], 8'h20));
    wr(`OFS_ID_ROM_ACCESS, 32'h0200_0000);
    wait_byte();
    rd(`OFS_ID_ROM_ACCESS, acc(u_id_rom_engine_model.mem[0], 8'h20));
    wr(`OFS_ID_ROM_ACCESS, 32'h8200_0000);
    wait_byte();
    rd(`OFS_ID_ROM_ACCESS, acc(u_id_rom_engine_model.mem[0], 8'h20));
    $display("byte read tests done");
    do_reset(1'b0);
    wr(`OFS_ID_ROM_ACCESS, 32'h0200_0000);
    rd(`OFS_INTERFACE_VERSION, 33'h0_0001_0010);
    rd(`OFS_ID_ROM_ACCESS, acc(`ROM_DATA_RESET, 8'h00));
    $display("absent rom tests done");
    u_id_rom_engine_model.mem[6] &= 8'hDF;
    do_reset(1'b1);
    rd(`OFS_INTERFACE_VERSION, 33'h0_0101_0010);
    rd(`OFS_ID_ROM_ACCESS, acc(`ROM_DATA_RESET, 8'h00));
    wr(`OFS_ID_ROM_ACCESS, 32'h0200_0000);
    wait_byte();
    rd(`OFS_ID_ROM_ACCESS, acc(u_id_rom_engine_model.mem[0], 8'h00));
    $display("reload tests done");
    repeat (2) @(posedge clk_in);
    check("notes left", 33'(exp_q.size() + ld_q.size()), 33'h0);
    finish_test();
  end
endmodule
`default_nettype wire
